// file: rtl/sram_strobe_pkg.sv
// shared types, constants and timing decode for the static memory strobe block
package sram_strobe_pkg;

	localparam int          NUM_CS       = 8;
	localparam int          CNT_W        = 10;
	localparam logic [1:0]  DBW_8        = 2'h0;
	localparam logic [1:0]  DBW_16       = 2'h1;
	localparam logic [1:0]  DBW_32       = 2'h2;
	localparam logic        BAT_SELECT   = 1'h0;
	localparam logic        BAT_WRITE    = 1'h1;
	localparam logic        MODE_CS      = 1'h0;
	localparam logic        MODE_STROBE  = 1'h1;
	localparam logic [7:0]  CS_IDLE      = 8'hFF;
	localparam logic [4:0]  PINS_IDLE    = 5'h1F;
	localparam logic [3:0]  LANES_IDLE   = 4'hF;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'h0,
		ST_ACCESS = 2'h1,
		ST_GAP    = 2'h3
	} ctrl_st_t;

	// timing codes per chip select, raw as software writes them
	typedef struct packed {
		logic [5:0] rd_setup;
		logic [5:0] cs_rd_setup;
		logic [5:0] we_setup;
		logic [5:0] cs_wr_setup;
		logic [6:0] rd_pulse;
		logic [6:0] cs_rd_pulse;
		logic [6:0] we_pulse;
		logic [6:0] cs_wr_pulse;
		logic [8:0] rd_cycle;
		logic [8:0] wr_cycle;
		logic [1:0] dbw;
		logic       byte_access_type;
		logic       read_mode;
		logic       write_mode;
	} cs_cfg_t;

	typedef struct packed {
		logic        write;
		logic [2:0]  cs;
		logic [25:0] addr;
		logic [31:0] wdata;
		logic [3:0]  be;
	} req_t;

	typedef struct packed {
		ctrl_st_t    st;
		req_t        cur;
		cs_cfg_t     cfg;
		logic [9:0]  cnt;
		logic        ready;
		logic [7:0]  cs_n;
		logic        rd_n;
		logic [4:0]  pins;
		logic [23:0] addr_hi;
		logic [31:0] dout;
		logic        doe;
		logic [31:0] rdata;
		logic        rvalid;
		logic        done;
	} ctrl_state_t;

	localparam ctrl_state_t STATE_RST = '{st: ST_IDLE, cur: '0, cfg: '0, cnt: '0, ready: 1'b1,
		cs_n: CS_IDLE, rd_n: 1'b1, pins: PINS_IDLE, addr_hi: '0, dout: '0, doe: 1'b0,
		rdata: '0, rvalid: 1'b0, done: 1'b0};

	// 128 x bit5 + bits 4..0
	function automatic logic [9:0] setup_eff(input logic [5:0] c);
		setup_eff = {2'h0, c[5], 2'h0, c[4:0]};
	endfunction : setup_eff

	// 256 x bit6 + bits 5..0
	function automatic logic [9:0] pulse_eff(input logic [6:0] c);
		pulse_eff = {1'h0, c[6], 2'h0, c[5:0]};
	endfunction : pulse_eff

	// 256 x bits 8..7 + bits 6..0
	function automatic logic [9:0] cycle_eff(input logic [8:0] c);
		cycle_eff = {c[8:7], 1'h0, c[6:0]};
	endfunction : cycle_eff

	function automatic logic [9:0] cycle_of(input cs_cfg_t c, input logic wr);
		cycle_of = wr ? cycle_eff(c.wr_cycle) : cycle_eff(c.rd_cycle);
	endfunction : cycle_of

	// true when the cycle after cnt is the first one past the pulse
	function automatic logic win_end(input logic [9:0] cnt, input logic [9:0] s, input logic [9:0] p);
		win_end = ({1'b0, cnt} + 11'h001) == ({1'b0, s} + {1'b0, p});
	endfunction : win_end

endpackage : sram_strobe_pkg

// file: rtl/strobe_window.sv
// active window of one strobe: asserted from setup for pulse cycles
`timescale 1ns/1ns
module strobe_window (
	input  logic [5:0] setup_code,
	input  logic [6:0] pulse_code,
	input  logic [9:0] cnt,
	output logic       active
);
	import sram_strobe_pkg::*;

	logic [10:0] s_ext;
	logic [10:0] e_ext;

	always_comb begin
		s_ext  = {1'b0, setup_eff(setup_code)};
		e_ext  = s_ext + {1'b0, pulse_eff(pulse_code)};
		active = ({1'b0, cnt} >= s_ext) && ({1'b0, cnt} < e_ext);
	end

endmodule : strobe_window

// file: rtl/pin_mux.sv
// translation of byte lanes, write strobe and low address onto the shared pins
`timescale 1ns/1ns
module pin_mux (
	input  logic [1:0] dbw,
	input  logic       byte_access_type,
	input  logic [1:0] addr_lo,
	input  logic [3:0] bs_n,
	input  logic [3:0] wr_n,
	input  logic       we_n,
	output logic [4:0] pins
);
	import sram_strobe_pkg::*;

	logic wide;
	logic sel;

	always_comb begin
		wide = (dbw == DBW_16) || (dbw == DBW_32);
		sel  = (byte_access_type == BAT_SELECT) || !wide;
		// unused pins park high so a stray device never sees a strobe
		pins[0] = wide ? (sel ? bs_n[0] : 1'b1) : addr_lo[0];
		pins[1] = sel ? we_n : wr_n[0];
		pins[2] = wide ? (sel ? bs_n[1] : wr_n[1]) : 1'b1;
		if (dbw == DBW_32) begin
			pins[3] = sel ? bs_n[2] : wr_n[2];
			pins[4] = sel ? bs_n[3] : wr_n[3];
		end else begin
			pins[3] = addr_lo[1];
			pins[4] = 1'b1;
		end
	end

endmodule : pin_mux

// file: rtl/static_mem_ctrl.sv
// static memory strobe sequencer: one access at a time on eight chip selects
`timescale 1ns/1ns

module static_mem_ctrl (
	input  logic                                           clk,
	input  logic                                           rst,
	input  logic                                           ce,
	input  sram_strobe_pkg::cs_cfg_t [7:0]                 cfg,
	input  logic                                           req_valid,
	input  sram_strobe_pkg::req_t                          req,
	output logic                                           req_ready,
	output logic [31:0]                                    rd_data,
	output logic                                           rd_valid,
	output logic                                           acc_done,
	output logic [7:0]                                     chip_select_n,
	output logic                                           read_strobe_n,
	output logic                                           shared_pin_0,
	output logic                                           shared_pin_1,
	output logic                                           shared_pin_2,
	output logic                                           shared_pin_3,
	output logic                                           shared_pin_4,
	output logic [23:0]                                    addr_hi,
	output logic [31:0]                                    data_out,
	output logic                                           data_oe,
	input  logic [31:0]                                    data_in
);
	import sram_strobe_pkg::*;

	ctrl_state_t s_ff;
	ctrl_state_t seq;
	ctrl_state_t nxt_s;

	logic        accept;
	logic        last;
	logic        samp;
	logic [9:0]  cyc_cur;
	logic        str_act;
	logic        cs_act;
	logic [5:0]  str_setup;
	logic [6:0]  str_pulse;
	logic [5:0]  csw_setup;
	logic [6:0]  csw_pulse;
	logic        a_run;
	logic        we_act;
	logic [3:0]  bs_n;
	logic [3:0]  wr_n;
	logic [4:0]  pins_nxt;
	logic [1:0]  addr_lo;
	logic [9:0]  oe_from;

	// sequencing: counter, acceptance and read sampling on the current cycle
	always_comb begin
		seq        = s_ff;
		seq.rvalid = 1'b0;
		seq.done   = 1'b0;
		accept     = req_valid && s_ff.ready;
		cyc_cur    = cycle_of(s_ff.cfg, s_ff.cur.write);
		// a zero cycle code is outside the legal range and wraps here
		last       = (s_ff.st == ST_ACCESS) && (s_ff.cnt == cyc_cur - 10'h001);
		// the mode bit alone chooses the sampling strobe
		if (s_ff.cfg.read_mode == MODE_STROBE) begin
			samp = win_end(s_ff.cnt, setup_eff(s_ff.cfg.rd_setup),
				pulse_eff(s_ff.cfg.rd_pulse));
		end else begin
			samp = win_end(s_ff.cnt, setup_eff(s_ff.cfg.cs_rd_setup),
				pulse_eff(s_ff.cfg.cs_rd_pulse));
		end
		case (s_ff.st)
			ST_IDLE: begin
				if (accept) begin
					seq.st  = ST_ACCESS;
					seq.cur = req;
					seq.cfg = cfg[req.cs];
					seq.cnt = '0;
				end
			end
			ST_GAP: begin
				// one dead cycle between two different devices avoids bus fights
				seq.st  = ST_ACCESS;
				seq.cnt = '0;
			end
			ST_ACCESS: begin
				if (!s_ff.cur.write && samp) begin
					seq.rdata  = data_in;
					seq.rvalid = 1'b1;
				end
				if (!last) begin
					seq.cnt = s_ff.cnt + 10'h001;
				end else begin
					seq.done = 1'b1;
					seq.cnt  = '0;
					if (accept) begin
						seq.cur = req;
						seq.cfg = cfg[req.cs];
						// same device restarts at once so zero setup/hold strobes never rise
						seq.st  = (req.cs == s_ff.cur.cs) ? ST_ACCESS : ST_GAP;
					end else begin
						seq.st = ST_IDLE;
					end
				end
			end
			default: begin
				seq.st = ST_IDLE;
			end
		endcase
	end

	// the outputs register the waveform of the cycle that seq describes
	always_comb begin
		if (seq.cur.write) begin
			str_setup = seq.cfg.we_setup;
			str_pulse = seq.cfg.we_pulse;
			csw_setup = seq.cfg.cs_wr_setup;
			csw_pulse = seq.cfg.cs_wr_pulse;
		end else begin
			str_setup = seq.cfg.rd_setup;
			str_pulse = seq.cfg.rd_pulse;
			csw_setup = seq.cfg.cs_rd_setup;
			csw_pulse = seq.cfg.cs_rd_pulse;
		end
	end

	strobe_window u_str_win (
		.setup_code (str_setup),
		.pulse_code (str_pulse),
		.cnt        (seq.cnt),
		.active     (str_act)
	);

	strobe_window u_cs_win (
		.setup_code (csw_setup),
		.pulse_code (csw_pulse),
		.cnt        (seq.cnt),
		.active     (cs_act)
	);

	always_comb begin
		a_run  = (seq.st == ST_ACCESS);
		we_act = a_run && seq.cur.write && str_act;
		// lanes stand for the whole access, like the address
		bs_n   = a_run ? ~seq.cur.be : LANES_IDLE;
		wr_n   = ~({4{we_act}} & seq.cur.be);
		if (seq.cfg.dbw == DBW_8) begin
			addr_lo = seq.cur.addr[1:0];
		end else if (seq.cfg.dbw == DBW_16) begin
			addr_lo = {seq.cur.addr[1], 1'b1};
		end else begin
			addr_lo = 2'h3;
		end
		oe_from = (seq.cfg.write_mode == MODE_STROBE) ? setup_eff(seq.cfg.we_setup)
			: setup_eff(seq.cfg.cs_wr_setup);
	end

	pin_mux u_pin_mux (
		.dbw     (seq.cfg.dbw),
		.byte_access_type     (seq.cfg.byte_access_type),
		.addr_lo (addr_lo),
		.bs_n    (bs_n),
		.wr_n    (wr_n),
		.we_n    (~we_act),
		.pins    (pins_nxt)
	);

	always_comb begin
		nxt_s         = seq;
		nxt_s.ready   = (seq.st == ST_IDLE) ||
			((seq.st == ST_ACCESS) && (seq.cnt == cycle_of(seq.cfg, seq.cur.write) - 10'h001));
		nxt_s.cs_n    = (a_run && cs_act) ? ~(8'h01 << seq.cur.cs) : CS_IDLE;
		nxt_s.rd_n    = !(a_run && !seq.cur.write && str_act);
		nxt_s.pins    = pins_nxt;
		nxt_s.addr_hi = seq.cur.addr[25:2];
		nxt_s.dout    = seq.cur.wdata;
		// data released between accesses and during reads
		nxt_s.doe     = a_run && seq.cur.write && (seq.cnt >= oe_from);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_ff <= STATE_RST;
		end else if (ce) begin
			s_ff <= nxt_s;
		end
	end

	assign req_ready     = s_ff.ready;
	assign rd_data       = s_ff.rdata;
	assign rd_valid      = s_ff.rvalid;
	assign acc_done      = s_ff.done;
	assign chip_select_n = s_ff.cs_n;
	assign read_strobe_n = s_ff.rd_n;
	assign shared_pin_0  = s_ff.pins[0];
	assign shared_pin_1  = s_ff.pins[1];
	assign shared_pin_2  = s_ff.pins[2];
	assign shared_pin_3  = s_ff.pins[3];
	assign shared_pin_4  = s_ff.pins[4];
	assign addr_hi       = s_ff.addr_hi;
	assign data_out      = s_ff.dout;
	assign data_oe       = s_ff.doe;

endmodule : static_mem_ctrl

// file: test/static_mem_ctrl_properties.sv
// port-level temporal checks for the strobe sequencer
`timescale 1ns/1ns
module static_mem_ctrl_checker (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        req_valid,
	input wire logic        req_ready,
	input wire logic [31:0] rd_data,
	input wire logic        rd_valid,
	input wire logic        acc_done,
	input wire logic [7:0]  chip_select_n,
	input wire logic        read_strobe_n,
	input wire logic        shared_pin_1,
	input wire logic [31:0] data_out,
	input wire logic        data_oe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property p_one_cs; $onehot0(~chip_select_n); endproperty
	a_one_cs: assert property (p_one_cs) else $error("two chip selects low");
	property p_cs_steady; (chip_select_n != 8'hFF) ##1 (chip_select_n != 8'hFF) |-> chip_select_n == $past(chip_select_n); endproperty
	a_cs_steady: assert property (p_cs_steady) else $error("chip select switched without idle");
	property p_rd_hold; !rd_valid |-> $stable(rd_data); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved without valid");
	property p_read_quiet; !read_strobe_n |-> !data_oe && shared_pin_1; endproperty
	a_read_quiet: assert property (p_read_quiet) else $error("write activity during read strobe");
	property p_oe_to_end; $fell(data_oe) |-> $past(req_ready); endproperty
	a_oe_to_end: assert property (p_oe_to_end) else $error("data released before cycle end");
	property p_data_steady; data_oe && $past(data_oe) && !$past(req_ready) |-> $stable(data_out); endproperty
	a_data_steady: assert property (p_data_steady) else $error("write data moved mid access");
	property p_take_done; req_valid && req_ready |-> ##[1:1000] acc_done; endproperty
	a_take_done: assert property (p_take_done) else $error("access never completed");
	property p_done_after_last; acc_done |-> $past(req_ready); endproperty
	a_done_after_last: assert property (p_done_after_last) else $error("done without last cycle");
	c_read: cover property ($rose(read_strobe_n));
	c_write: cover property ($fell(data_oe));
	c_chained: cover property (req_valid && req_ready && chip_select_n != 8'hFF);
endmodule : static_mem_ctrl_checker

bind static_mem_ctrl static_mem_ctrl_checker static_mem_ctrl_checker_i (.clk(clk), .rst(rst), .req_valid(req_valid),
	.req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid), .acc_done(acc_done), .chip_select_n(chip_select_n),
	.read_strobe_n(read_strobe_n), .shared_pin_1(shared_pin_1), .data_out(data_out), .data_oe(data_oe));

// file: test/sram_partner.sv
// far-side memory: answers reads with a word built from the address
`timescale 1ns/1ns
module sram_partner (
	input  wire logic        clk,
	input  wire logic [7:0]  chip_select_n,
	input  wire logic        read_strobe_n,
	input  wire logic [23:0] addr_hi,
	output logic      [31:0] data_in
);
	logic [31:0] last_ff = 32'h0;
	// released bus flips every cycle so a stale word never passes
	always_comb data_in = (chip_select_n != 8'hFF || !read_strobe_n) ? {addr_hi[7:0], ~addr_hi} : ~last_ff;
	always @(posedge clk) last_ff <= data_in;
endmodule : sram_partner

// file: test/static_mem_ctrl_bench.sv
// bench: random and directed accesses against a cycle model
`timescale 1ns/1ns
module static_mem_ctrl_bench;
	import sram_strobe_pkg::*;
	logic          clk = 1'b0, rst = 1'b1, req_valid = 1'b0, busy = 1'b0;
	cs_cfg_t [7:0] cfg = '0;
	req_t          req = '0;
	logic          req_ready, rd_valid, acc_done, read_strobe_n, data_oe;
	logic [4:0]    pins;
	logic [7:0]    chip_select_n;
	logic [23:0]   addr_hi;
	logic [31:0]   rd_data, data_out, data_in, seed = 32'h12D9;
	logic [31:0]   rdq[$];
	int            num_errors = 0, compares = 0;
	int            dones = 0;
	int            ends = 0;
	logic          tail = 1'b0;
	logic [2:0]    pcs = 3'h0;

	// clock enable tied high: stretch behaviour stays unexercised
	static_mem_ctrl static_mem_ctrl_i (.clk(clk), .rst(rst), .ce(1'b1), .cfg(cfg), .req_valid(req_valid), .req(req),
		.req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid), .acc_done(acc_done),
		.chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n), .shared_pin_0(pins[0]), .shared_pin_1(pins[1]),
		.shared_pin_2(pins[2]), .shared_pin_3(pins[3]), .shared_pin_4(pins[4]), .addr_hi(addr_hi),
		.data_out(data_out), .data_oe(data_oe), .data_in(data_in));
	sram_partner sram_partner_i (.clk(clk), .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
		.addr_hi(addr_hi), .data_in(data_in));

	always #5 clk = ~clk;

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	function automatic int eff(input int v, input int lo, input int wt);
		return wt * (v >> lo) + v % (1 << lo);
	endfunction : eff

	function automatic cs_cfg_t mk(input int a, b, c, d, e, f, g, h, i, j, k, l, m, n);
		return {6'(a), 6'(b), 6'(c), 6'(d), 7'(e), 7'(f), 7'(g), 7'(h), 9'(i), 9'(j), 2'(k), 1'(l), 1'(m), 1'(n)};
	endfunction : mk

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic rand_cfg(input int i);
		int s[4], p[4];
		for (int j = 0; j < 4; j++) begin
			s[j] = rnd() % 4;
			p[j] = 1 + rnd() % 4;
		end
		// at least one hold cycle on every random setting
		cfg[i] <= mk(s[0], s[1], s[2], s[3], p[0], p[1], p[2], p[3],
			(s[0] + p[0] > s[1] + p[1] ? s[0] + p[0] : s[1] + p[1]) + 1 + rnd() % 2,
			(s[2] + p[2] > s[3] + p[3] ? s[2] + p[2] : s[3] + p[3]) + 1 + rnd() % 2,
			rnd() % 3, rnd() % 2, rnd() % 2, rnd() % 2);
	endtask : rand_cfg

	task automatic acc(input logic w, input logic [2:0] c, input logic [31:0] a, input logic [31:0] d, input logic b2b);
		int n;
		n = 0;
		do @(posedge clk); while (busy === 1'b1 && !b2b && ++n < 2000);
		req <= '{write: w, cs: c, addr: a[25:0], wdata: d, be: a[29:26] | 4'h1};
		req_valid <= 1'b1;
		do @(posedge clk); while (req_ready !== 1'b1 && ++n < 4000);
		req_valid <= 1'b0;
		// a stuck handshake counts as a mismatch
		check(32'(n < 2000), 32'h1, "request taken");
	endtask : acc

	always begin : model
		cs_cfg_t f;
		req_t r;
		int c, s, p, cs_s, cs_p, k;
		logic wa, eoe;
		logic [3:0] ln;
		logic [4:0] ep;
		logic [7:0] ecs;
		@(posedge clk);
		if (req_valid === 1'b1 && req_ready === 1'b1 && !rst) begin
			busy = 1'b1;
			r = req;
			f = cfg[r.cs];
			c = eff(r.write ? f.wr_cycle : f.rd_cycle, 7, 256);
			s = eff(r.write ? f.we_setup : f.rd_setup, 5, 128);
			p = eff(r.write ? f.we_pulse : f.rd_pulse, 6, 256);
			cs_s = eff(r.write ? f.cs_wr_setup : f.cs_rd_setup, 5, 128);
			cs_p = eff(r.write ? f.cs_wr_pulse : f.cs_rd_pulse, 6, 256);
			if (!r.write) rdq.push_back({r.addr[9:2], ~r.addr[25:2]});
			// chained to another device: one dead cycle first
			if (tail && r.cs != pcs) begin
				@(negedge clk);
				check(32'({chip_select_n, read_strobe_n, data_oe, req_ready}), 32'h7FC, "gap cycle");
			end
			for (k = 0; k < c; k++) begin
				@(negedge clk);
				wa = r.write && k >= s && k < s + p;
				ecs = 8'hFF;
				ecs[r.cs] = !(k >= cs_s && k < cs_s + cs_p);
				ln = f.byte_access_type == BAT_SELECT ? ~r.be : ~({4{wa}} & r.be);
				ep = {f.dbw == DBW_32 ? ln[3] : 1'b1, f.dbw == DBW_32 ? ln[2] : r.addr[1], f.dbw == DBW_8 ? 1'b1 : ln[1],
					(f.byte_access_type == BAT_SELECT || f.dbw == DBW_8) ? !wa : ln[0],
					f.dbw == DBW_8 ? r.addr[0] : (f.byte_access_type == BAT_SELECT ? ~r.be[0] : 1'b1)};
				eoe = r.write && k >= (f.write_mode ? s : cs_s);
				check(32'(chip_select_n), 32'(ecs), "chip select");
				check(32'(read_strobe_n), 32'(r.write || !(k >= s && k < s + p)), "read strobe");
				check(32'(pins), 32'(ep), "shared pins");
				check(32'(addr_hi), 32'(r.addr[25:2]), "address");
				check(32'(data_oe), 32'(eoe), "data enable");
				if (eoe) check(data_out, r.wdata, "write data");
				check(32'(req_ready), 32'(k == c - 1), "ready");
			end
			pcs = r.cs;
			tail = 1'b1;
			ends++;
			busy = 1'b0;
		end else begin
			tail = 1'b0;
		end
	end

	always @(negedge clk) if (rd_valid === 1'b1) check(rd_data, rdq.pop_front(), "read data");
	always @(negedge clk) if (acc_done === 1'b1) dones++;

	task automatic report_and_stop();
		$display("comparisons %0d, mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop

	initial begin : watchdog
		#200000;
		num_errors++;
		report_and_stop();
	end

	initial begin : main
		logic [31:0] v;
		logic [2:0] last_cs;
		last_cs = 3'h0;
		@(posedge clk);
		for (int i = 0; i < 8; i++) rand_cfg(i);
		repeat (4) @(posedge clk);
		check(32'({chip_select_n, read_strobe_n, pins, data_oe}), 32'h7FFE, "idle pins");
		rst <= 1'b0;
		for (int i = 0; i < 40; i++) begin
			v = rnd();
			acc(v[0], v[3:1], rnd(), rnd(), v[3:1] == last_cs);
			last_cs = v[3:1];
		end
		$display("test random done");
		// zero setup and hold, chained on one chip select
		cfg[1] <= mk(0, 0, 0, 0, 3, 3, 2, 2, 3, 2, 2, 0, 1, 1);
		for (int i = 0; i < 6; i++) acc(i > 2, 3'h1, rnd(), rnd(), i > 0);
		$display("test chained done");
		// weighted top bits of every code except the two write setup codes
		cfg[2] <= mk(33, 32, 1, 0, 65, 66, 64, 65, 256, 129, 1, 1, 0, 0);
		// chained straight after the chip select 1 write, so the dead cycle is crossed
		acc(1'b0, 3'h2, rnd(), rnd(), 1'b1);
		acc(1'b1, 3'h2, rnd(), rnd(), 1'b1);
		do @(posedge clk); while (busy === 1'b1);
		repeat (3) @(posedge clk);
		check(32'(rdq.size()), 32'h0, "reads left over");
		check(32'(dones), 32'(ends), "accesses done");
		$display("test long codes done");
		report_and_stop();
	end
endmodule : static_mem_ctrl_bench
